//--- hw/udec_endpoint.sv
// one usb device endpoint: registers, banked fifo and token handling
`timescale 1ns/1ns
module udec_endpoint #(
  parameter int DEPTH     = 64,
  parameter bit DUAL_BANK = 1'b1
) (
  input  wire logic                   MCLK,
  input  wire logic                   RESET_N,
  input  wire logic [7:0]             ADDR,
  input  wire logic [31:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic [31:0]                 RDATA,
  input  wire udec_pkg::udec_sie_in_t SIE_IN,
  output udec_pkg::udec_sie_out_t     SIE_OUT,
  output logic                        XCVR_OFF
);

  localparam int AW = $clog2(DEPTH);
  // rx stores an out or setup packet; ack wait follows sent in data except on iso endpoints
  typedef enum {ST_IDLE, ST_RX, ST_TX, ST_ACKW} udec_state_t;

  // ========================================================================
  // storage
  // two receive banks side by side; the top index bit picks the bank
  logic [7:0] rx_mem [0:2*DEPTH-1];
  logic [7:0] tx_mem [0:DEPTH-1];

  udec_state_t state_q;
  logic        tx_complete_q, bk0_q, bk1_q, setup_q, staller_q, txrdy_q;
  logic        fstall_q, dir_q, toggle_q, epon_q, seen_q, xoff_q;
  logic [2:0]  kind_q;
  logic        rx_setup_q, wr_bank_q, rx_bank_q;
  logic [udec_pkg::CNT_W-1:0] cnt0_q, cnt1_q, wptr_q, rptr_q;
  logic [udec_pkg::CNT_W-1:0] tcnt_q, tptr_q;
  logic [31:0] rdata_q;
  udec_pkg::udec_sie_out_t sout_q;

  // ========================================================================
  // register decode
  // exact address match; unmapped offsets read zero and ignore writes
  wire csr_wr  = WR && (ADDR == udec_pkg::REG_CSR);
  wire fdr_wr  = WR && (ADDR == udec_pkg::REG_FDR);
  wire txvc_wr = WR && (ADDR == udec_pkg::REG_TXVC);
  wire fdr_rd  = RD && (ADDR == udec_pkg::REG_FDR);

  wire is_ctrl = (kind_q[1:0] == udec_pkg::TYPE_CTRL);
  wire is_iso  = (kind_q[1:0] == udec_pkg::TYPE_ISO);
  // a disabled endpoint stays silent, not even a nak
  wire enabled = is_ctrl || epon_q;

  // a firmware zero clears, a one leaves alone; for tx ready a one sets and a zero leaves alone
  wire clr_tx_complete  = csr_wr && !WDATA[udec_pkg::B_TX_COMPLETE];
  wire clr_bk0     = csr_wr && !WDATA[udec_pkg::B_BK0];
  wire clr_bk1     = csr_wr && !WDATA[udec_pkg::B_BK1];
  wire clr_setup   = csr_wr && !WDATA[udec_pkg::B_SETUP];
  wire clr_staller = csr_wr && !WDATA[udec_pkg::B_STALLER];
  wire set_txrdy   = csr_wr && WDATA[udec_pkg::B_TXRDY];

  // ========================================================================
  // bank selection
  wire bank1_ok  = DUAL_BANK;
  wire wbank     = bank1_ok && wr_bank_q;
  wire wbank_free = wbank ? !bk1_q : (!bk0_q && !setup_q);
  // with both banks full, firmware drains bank 0 first
  wire rd_bank   = bank1_ok && !(bk0_q || setup_q) && bk1_q;
  wire [udec_pkg::CNT_W-1:0] rd_cnt = rd_bank ? cnt1_q : cnt0_q;
  wire [udec_pkg::CNT_W-1:0] rx_count = rd_cnt - rptr_q;
  wire [AW:0] rd_idx = {rd_bank, rptr_q[AW-1:0]};
  wire [AW:0] wr_idx = {rx_bank_q, wptr_q[AW-1:0]};
  // bytes beyond a bank are dropped rather than spilling into the other
  wire room = (wptr_q < udec_pkg::CNT_W'(DEPTH));
  wire tx_room = (tcnt_q < udec_pkg::CNT_W'(DEPTH));

  // ========================================================================
  // token acceptance; control direction reversal for the status stage
  // seen_q marks a finished data stage; only then is the reverse allowed
  wire out_dir_ok = is_ctrl ? (!setup_q && (!dir_q || seen_q))
                            : !kind_q[2];
  wire in_dir_ok  = is_ctrl ? (!setup_q && (dir_q || seen_q))
                            : kind_q[2];
  wire idle     = (state_q == ST_IDLE);
  wire tok_in   = idle && SIE_IN.in_tok && enabled;
  wire tok_out  = idle && SIE_IN.out_tok && enabled;
  wire tok_set  = idle && SIE_IN.setup_tok && is_ctrl;
  wire stall_hs = (tok_in || tok_out) && fstall_q;
  wire out_go   = tok_out && !fstall_q && out_dir_ok && wbank_free;
  wire out_nak  = tok_out && !fstall_q && !out_go;
  wire in_go    = tok_in && !fstall_q && in_dir_ok && txrdy_q;
  wire in_nak   = tok_in && !fstall_q && !in_go;

  // ========================================================================
  // packet end events
  wire in_rx    = (state_q == ST_RX);
  wire rx_good  = in_rx && SIE_IN.rx_ok;
  // a bad iso packet is still kept; the shared error flag marks it
  wire rx_iso_bad = in_rx && SIE_IN.rx_bad && is_iso && !rx_setup_q;
  wire rx_store = (rx_good || rx_iso_bad) && !rx_setup_q;
  wire set_bk0  = rx_store && !rx_bank_q;
  wire set_bk1  = rx_store && rx_bank_q;
  wire set_setup = rx_good && rx_setup_q;
  // iso in has no ack phase, so the closing request ends the transfer
  wire tx_done_iso = (state_q == ST_TX) && SIE_IN.tx_req && is_iso
                     && (tptr_q >= tcnt_q);
  wire acked    = (state_q == ST_ACKW) && SIE_IN.host_ack;
  wire tx_fin   = acked || tx_done_iso;
  // releasing any full bank rewinds the read pointer
  wire rel_bank = (clr_bk0 && bk0_q) || (clr_bk1 && bk1_q)
                  || (clr_setup && setup_q);

  // ========================================================================
  // read data mux
  logic [31:0] csr_rd;
  always_comb
  begin
    csr_rd = 32'h0;
    csr_rd[udec_pkg::B_TX_COMPLETE]  = tx_complete_q;
    csr_rd[udec_pkg::B_BK0]     = bk0_q;
    csr_rd[udec_pkg::B_SETUP]   = setup_q;
    csr_rd[udec_pkg::B_STALLER] = staller_q;
    csr_rd[udec_pkg::B_TXRDY]   = txrdy_q;
    csr_rd[udec_pkg::B_FSTALL]  = fstall_q;
    csr_rd[udec_pkg::B_BK1]     = bk1_q;
    csr_rd[udec_pkg::B_DIR]     = dir_q;
    csr_rd[udec_pkg::B_KIND+:3] = kind_q;
    csr_rd[udec_pkg::B_TOGGLE]  = toggle_q;
    csr_rd[udec_pkg::B_EPON]    = enabled;
    csr_rd[udec_pkg::B_RXCNT+:udec_pkg::CNT_W] = rx_count;
  end

  logic [31:0] txvc_rd;
  always_comb
  begin
    txvc_rd = 32'h0;
    txvc_rd[udec_pkg::B_XCVROFF] = xoff_q;
  end

  wire [31:0] fdr_rd_w = {24'h0, rx_mem[rd_idx]};
  wire [31:0] rd_mux = (ADDR == udec_pkg::REG_CSR)  ? csr_rd  :
                       (ADDR == udec_pkg::REG_FDR)  ? fdr_rd_w :
                       (ADDR == udec_pkg::REG_TXVC) ? txvc_rd : 32'h0;

  // ========================================================================
  // bus slave: read data valid in the cycle after the strobe only
  // the slave never stalls, so no wait state exists
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rdata_q <= 32'h0;
    else
      rdata_q <= RD ? rd_mux : 32'h0;
  end

  // ========================================================================
  // firmware configuration
  // the enable bit is stored for every kind; control ignores it on read
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      kind_q   <= udec_pkg::KIND_RST;
      dir_q    <= 1'b0;
      fstall_q <= 1'b0;
      epon_q   <= 1'b0;
      xoff_q   <= udec_pkg::XCVR_OFF_RST;
    end
    else
    begin
      if (csr_wr)
      begin
        kind_q   <= WDATA[udec_pkg::B_KIND+:3];
        dir_q    <= WDATA[udec_pkg::B_DIR];
        fstall_q <= WDATA[udec_pkg::B_FSTALL];
        epon_q   <= WDATA[udec_pkg::B_EPON];
      end
      if (txvc_wr)
        xoff_q <= WDATA[udec_pkg::B_XCVROFF];
    end
  end

  // ========================================================================
  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tx_complete_q  <= 1'b0;
      bk0_q     <= 1'b0;
      bk1_q     <= 1'b0;
      setup_q   <= 1'b0;
      staller_q <= 1'b0;
      txrdy_q   <= 1'b0;
    end
    else
    begin
      tx_complete_q  <= tx_fin || (tx_complete_q && !clr_tx_complete);
      bk0_q     <= set_bk0 || (bk0_q && !clr_bk0);
      bk1_q     <= set_bk1 || (bk1_q && !clr_bk1);
      setup_q   <= set_setup || (setup_q && !clr_setup);
      // stall and iso error share one flag
      staller_q <= stall_hs || rx_iso_bad
                   || (staller_q && !clr_staller);
      // a firmware set beats the hardware clear in the same cycle
      txrdy_q   <= set_txrdy || (txrdy_q && !tx_fin);
    end
  end

  // ========================================================================
  // transmit side: firmware pushes bytes while tx ready is low
  // pushes while tx ready is high are dropped so the held payload stays
  always_ff @(posedge MCLK)
  begin
    if (fdr_wr && !txrdy_q && tx_room)
      tx_mem[tcnt_q[AW-1:0]] <= WDATA[7:0];
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    // the count rewinds once the payload has gone
    if (!RESET_N)
      tcnt_q <= '0;
    else if (tx_fin)
      tcnt_q <= '0;
    else if (fdr_wr && !txrdy_q && tx_room)
      tcnt_q <= tcnt_q + 1'b1;
  end

  // ========================================================================
  // receive side: firmware pops bank 0 while it is full, else bank 1
  // a pop at count zero is ignored instead of wrapping the read pointer
  always_ff @(posedge MCLK)
  begin
    if (in_rx && SIE_IN.rx_valid && room)
      rx_mem[wr_idx] <= SIE_IN.rx_data;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rptr_q <= '0;
    else if (rel_bank)
      rptr_q <= '0;
    else if (fdr_rd && (rx_count != '0))
      rptr_q <= rptr_q + 1'b1;
  end

  // ========================================================================
  // token sequencer
  // tokens are only taken in idle; anything arriving mid-packet is ignored
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q    <= ST_IDLE;
      rx_setup_q <= 1'b0;
      rx_bank_q  <= 1'b0;
      wr_bank_q  <= 1'b0;
      wptr_q     <= '0;
      tptr_q     <= '0;
      cnt0_q     <= '0;
      cnt1_q     <= '0;
      toggle_q   <= 1'b0;
      seen_q     <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          // pointers rewind between packets
          wptr_q <= '0;
          tptr_q <= '0;
          if (tok_set)
          begin
            state_q    <= ST_RX;
            rx_setup_q <= 1'b1;
            rx_bank_q  <= 1'b0;
            seen_q     <= 1'b0;
          end
          else if (out_go)
          begin
            state_q    <= ST_RX;
            rx_setup_q <= 1'b0;
            rx_bank_q  <= wbank;
          end
          else if (in_go)
            state_q <= ST_TX;
        end
        ST_RX:
        begin
          if (SIE_IN.rx_valid && room)
            wptr_q <= wptr_q + 1'b1;
          if (SIE_IN.rx_ok || SIE_IN.rx_bad)
            state_q <= ST_IDLE;
          if (set_setup)
          begin
            cnt0_q   <= wptr_q;
            toggle_q <= 1'b1;
          end
          if (rx_store)
          begin
            if (rx_bank_q)
              cnt1_q <= wptr_q;
            else
              cnt0_q <= wptr_q;
            toggle_q  <= !toggle_q;
            wr_bank_q <= bank1_ok && !rx_bank_q;
            if (is_ctrl && !dir_q)
              seen_q <= 1'b1;
          end
        end
        ST_TX:
        begin
          if (SIE_IN.tx_req && (tptr_q < tcnt_q))
            tptr_q <= tptr_q + 1'b1;
          if (SIE_IN.tx_req && (tptr_q >= tcnt_q))
            state_q <= is_iso ? ST_IDLE : ST_ACKW;
        end
        ST_ACKW:
        begin
          // a missing ack leaves tx ready set, so the next in retries
          // limitation: with neither ack nor error the endpoint waits here
          if (SIE_IN.host_ack || SIE_IN.rx_bad)
            state_q <= ST_IDLE;
          if (acked)
          begin
            toggle_q <= !toggle_q;
            if (is_ctrl && dir_q)
              seen_q <= 1'b1;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // answers to the serial engine
  wire tx_byte = (state_q == ST_TX) && SIE_IN.tx_req && (tptr_q < tcnt_q);
  // a zero-length packet ends on its first request; the closing request
  // after the last byte must not repeat the end mark
  wire tx_end  = (state_q == ST_TX) && SIE_IN.tx_req
                 && ((tptr_q + 1'b1 == tcnt_q) || (tcnt_q == '0));
  // iso data is never acknowledged; the host expects no handshake
  wire hs_out  = stall_hs || out_nak || in_nak || (rx_good && !is_iso);
  udec_pkg::udec_hs_t hs_code_w;
  assign hs_code_w = stall_hs ? udec_pkg::HS_STALL :
                     (out_nak || in_nak) ? udec_pkg::HS_NAK :
                     udec_pkg::HS_ACK;

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      sout_q <= '0;
    else
    begin
      sout_q.hs_valid <= hs_out;
      sout_q.hs_code  <= hs_code_w;
      sout_q.tx_valid <= tx_byte;
      sout_q.tx_data  <= tx_byte ? tx_mem[tptr_q[AW-1:0]] : 8'h0;
      sout_q.tx_last  <= tx_end;
    end
  end

  // ========================================================================
  // outputs, straight from flip-flops
  assign RDATA    = rdata_q;
  assign SIE_OUT  = sout_q;
  assign XCVR_OFF = xoff_q;

endmodule : udec_endpoint

//--- hw/udec_pkg.sv
// constants, types and register layout of the usb endpoint control block
// ==========================================================================
// Contract
// - iso endpoint crc error sets shared error flag
// - writing zero clears iso error; one ignored
// - firmware sets tx ready; hardware alone clears
// - tx ready held payload answers next in
// - tx complete set when host acks payload
// - force stall bit makes endpoint answer stall
// - stall handshake sent sets stall acked flag
// - packet stored in bank one sets flag
// - firmware writes zero to release bank one
// - second bank used only by dual-bank endpoints
// - control direction bit selects data stage direction
// - status stage direction reversed by hardware itself
// - three-bit kind field, reset to control
// - enable bit gates non-control endpoints only
// - eleven-bit received byte count, read only
// - byte fifo register: write pushes, read pops
// - transceiver off bit, set by reset
// - writing zero clears stall acked; one ignored
// - packet stored in bank zero sets flag
package udec_pkg;

  // ========================================================================
  // register map
  localparam logic [7:0] REG_CSR  = 8'h00;
  localparam logic [7:0] REG_FDR  = 8'h04;
  localparam logic [7:0] REG_TXVC = 8'h08;

  // ========================================================================
  // control/status field positions
  localparam int B_TX_COMPLETE  = 0;
  localparam int B_BK0     = 1;
  localparam int B_SETUP   = 2;
  localparam int B_STALLER = 3;
  localparam int B_TXRDY   = 4;
  localparam int B_FSTALL  = 5;
  localparam int B_BK1     = 6;
  localparam int B_DIR     = 7;
  localparam int B_KIND    = 8;
  localparam int B_TOGGLE  = 11;
  localparam int B_EPON    = 15;
  localparam int B_RXCNT   = 16;
  localparam int B_XCVROFF = 8;
  localparam int CNT_W     = 11;

  // ========================================================================
  // reset values
  localparam logic [2:0] KIND_RST     = 3'h0;
  localparam logic       XCVR_OFF_RST = 1'b1;

  // ========================================================================
  // endpoint kinds: bit 2 is direction in, bits 1:0 the transfer type
  localparam logic [2:0] KIND_CTRL     = 3'h0;
  localparam logic [2:0] KIND_ISO_OUT  = 3'h1;
  localparam logic [2:0] KIND_ISO_IN   = 3'h5;
  localparam logic [2:0] KIND_BULK_OUT = 3'h2;
  localparam logic [2:0] KIND_BULK_IN  = 3'h6;
  localparam logic [2:0] KIND_INT_OUT  = 3'h3;
  localparam logic [2:0] KIND_INT_IN   = 3'h7;
  localparam logic [1:0] TYPE_CTRL     = 2'h0;
  localparam logic [1:0] TYPE_ISO      = 2'h1;

  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} udec_hs_t;

  // events and data from the serial engine, same clock
  typedef struct packed {
    logic       in_tok;
    logic       out_tok;
    logic       setup_tok;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_ok;
    logic       rx_bad;
    logic       host_ack;
    logic       tx_req;
  } udec_sie_in_t;

  // answers to the serial engine
  typedef struct packed {
    logic       hs_valid;
    udec_hs_t   hs_code;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_last;
  } udec_sie_out_t;

endpackage : udec_pkg

//--- verification/udec_props.sv
// concurrent checks on the ports of the usb endpoint block
`timescale 1ns/1ns
module udec_props (
  input wire logic                    MCLK,
  input wire logic                    RESET_N,
  input wire logic [7:0]              ADDR,
  input wire logic [31:0]             WDATA,
  input wire logic                    WR,
  input wire logic                    RD,
  input wire logic [31:0]             RDATA,
  input wire udec_pkg::udec_sie_in_t  SIE_IN,
  input wire udec_pkg::udec_sie_out_t SIE_OUT,
  input wire logic                    XCVR_OFF
);
  // ==========================================================================
  // helper state: last written stall bit, stall handshake not yet cleared
  logic fstall_q;
  logic stall_seen_q;
  wire  csr_wr   = WR && ADDR == udec_pkg::REG_CSR;
  wire  sa_clr   = csr_wr && !WDATA[udec_pkg::B_STALLER];
  wire  stall_hs = SIE_OUT.hs_valid && SIE_OUT.hs_code == udec_pkg::HS_STALL;
  always_ff @(posedge MCLK or negedge RESET_N)
    if (!RESET_N)
      fstall_q <= 1'b0;
    else if (csr_wr)
      fstall_q <= WDATA[udec_pkg::B_FSTALL];
  // hardware set wins over a clearing write in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N)
    if (!RESET_N)
      stall_seen_q <= 1'b0;
    else
      stall_seen_q <= stall_hs || (stall_seen_q && !sa_clr);
  // ==========================================================================
  // properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence s_csr_rd;
    RD && ADDR == udec_pkg::REG_CSR;
  endsequence
  a_xcvr_reset: assert property ($rose(RESET_N) |-> XCVR_OFF)
    else $error("transceiver not off after reset");
  a_xcvr_write: assert property (WR && ADDR == udec_pkg::REG_TXVC
    |=> XCVR_OFF == $past(WDATA[udec_pkg::B_XCVROFF]))
    else $error("transceiver bit does not follow write");
  a_txvc_read: assert property (RD && ADDR == udec_pkg::REG_TXVC
    |=> RDATA == {23'h0, $past(XCVR_OFF), 8'h0})
    else $error("transceiver register reads wrong");
  a_count_width: assert property (s_csr_rd |=>
    RDATA[31:27] == 5'h0 && RDATA[14:12] == 3'h0)
    else $error("status register unused bits set");
  a_ctrl_enabled: assert property (s_csr_rd |=>
    RDATA[10:8] != udec_pkg::KIND_CTRL || RDATA[udec_pkg::B_EPON])
    else $error("control endpoint reads disabled");
  a_fifo_byte: assert property (RD && ADDR == udec_pkg::REG_FDR
    |=> RDATA[31:8] == 24'h0)
    else $error("fifo read wider than a byte");
  a_stall_code: assert property (SIE_OUT.hs_valid |->
    (SIE_OUT.hs_code == udec_pkg::HS_STALL) == fstall_q)
    else $error("stall handshake disagrees with stall bit");
  a_stall_flag: assert property (s_csr_rd ##0 stall_seen_q |=>
    RDATA[udec_pkg::B_STALLER])
    else $error("stall flag not set after stall handshake");
  a_tx_cause: assert property (SIE_OUT.tx_valid || SIE_OUT.tx_last
    |-> $past(SIE_IN.tx_req))
    else $error("tx data without a request");
  a_last_once: assert property (SIE_OUT.tx_last
    |=> !SIE_OUT.tx_last)
    else $error("end of packet marked twice");
endmodule : udec_props

//--- verification/udec_host.sv
// behavioural usb host facing the serial-engine side of the endpoint
`timescale 1ns/1ns
module udec_host (
  input  wire logic                    mclk,
  input  wire udec_pkg::udec_sie_out_t sie_out,
  output udec_pkg::udec_sie_in_t       sie_in
);
  // ==========================================================================
  // drive helpers: quiet data lines toggle, so stale bytes never look valid
  initial
    sie_in = '0;
  task automatic put(input udec_pkg::udec_sie_in_t v);
    @(posedge mclk);
    sie_in <= v;
  endtask : put
  task automatic idle(input int n);
    repeat (n) put('{rx_data: ~sie_in.rx_data, default: '0});
  endtask : idle
  // ==========================================================================
  // transactions
  task automatic tok(input bit out);
    put('{in_tok: !out, out_tok: out, default: '0});
    idle(4);
  endtask : tok
  task automatic out_tx(input bit stp, input int n, input logic [7:0] d,
                        input bit bad);
    put('{out_tok: !stp, setup_tok: stp, default: '0});
    for (int i = 0; i < n; i++)
      put('{rx_valid: 1'b1, rx_data: d + 8'(i), default: '0});
    put('{rx_ok: !bad, rx_bad: bad, rx_data: ~d, default: '0});
    idle(4);
  endtask : out_tx
  // the last byte is seen one cycle late; that cycle is the closing request
  task automatic in_tx(input bit ack);
    put('{in_tok: 1'b1, default: '0});
    put('{tx_req: 1'b1, default: '0});
    for (int i = 0; i < 80 && !sie_out.tx_last; i++)
      @(posedge mclk);
    sie_in <= '{rx_data: ~sie_in.rx_data, default: '0};
    put('{host_ack: ack, rx_bad: !ack, default: '0});
    idle(4);
  endtask : in_tx
endmodule : udec_host

//--- verification/udec_endpoint_tb.sv
// self-checking bench for the usb endpoint block with a host model
`timescale 1ns/1ns
module udec_endpoint_tb;
  // ==========================================================================
  // signals and instances
  logic                    MCLK, RESET_N, WR, RD, XCVR_OFF;
  logic [7:0]              ADDR;
  logic [31:0]             WDATA, RDATA;
  udec_pkg::udec_sie_in_t  SIE_IN;
  udec_pkg::udec_sie_out_t SIE_OUT;
  int                      num_errors = 0;
  int                      checks = 0;
  logic [31:0]             rq[$], rm[$], hq[$], tq[$];
  logic                    rd_p = 1'b0;
  udec_endpoint u_udec_endpoint (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SIE_IN(SIE_IN),
    .SIE_OUT(SIE_OUT), .XCVR_OFF(XCVR_OFF));
  udec_host u_udec_host (.mclk(MCLK), .sie_out(SIE_OUT), .sie_in(SIE_IN));
  // ==========================================================================
  // clock, comparison and register tasks
  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m = '1);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    rq.push_back(e & m);
    rm.push_back(m);
    @(posedge MCLK);
    RD <= 1'b0;
  endtask : rd
  task automatic wc(input logic [31:0] d);
    wr(udec_pkg::REG_CSR, d);
  endtask : wc
  task automatic rc(input logic [31:0] e, m = '1);
    rd(udec_pkg::REG_CSR, e, m);
  endtask : rc
  // flag byte 8'h4f keeps every write-zero-to-clear flag as it is
  function automatic logic [31:0] csr(logic [2:0] k, logic on, logic [7:0] f);
    return {16'h0, on, 4'h0, k, f};
  endfunction : csr
  // ==========================================================================
  // result watcher: an unexpected result meets an empty queue and fails
  always @(posedge MCLK)
  begin
    if (rd_p)
      chk("rdata", rq.size() ? rq.pop_front() : 32'h1,
          RDATA & (rm.size() ? rm.pop_front() : 32'h0));
    if (SIE_OUT.hs_valid)
      chk("handshake", hq.size() ? hq.pop_front() : 32'h9,
          32'(SIE_OUT.hs_code));
    if (SIE_OUT.tx_valid || SIE_OUT.tx_last)
      chk("tx byte", tq.size() ? tq.pop_front() : 32'h9ff,
          {23'h0, SIE_OUT.tx_last, SIE_OUT.tx_data});
    rd_p = RD;
  end
  initial
  begin
    repeat (20000) @(posedge MCLK);
    num_errors++;
    stop_test();
  end
  // ==========================================================================
  // scenarios
  initial
  begin
    int k, n, n2;
    logic [7:0] d, d2;
    {ADDR, WDATA, WR, RD, RESET_N} = '0;
    void'($urandom(32'h408c));
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    rc(32'h8000);
    rd(udec_pkg::REG_TXVC, 32'h100);
    wr(udec_pkg::REG_TXVC, 32'h0);
    rd(udec_pkg::REG_TXVC, 32'h0);
    rd(8'h0c, 32'h0);
    for (k = 0; k < 8; k++)
      if (k != 4)
      begin
        wc(csr(3'(k), 1'b0, 8'h4f));
        rc(csr(3'(k), k == 0, 8'h0), 32'h8700);
      end
    wc(csr(3'h2, 1'b0, 8'h4f));
    u_udec_host.tok(1'b1);
    wc(csr(3'h2, 1'b1, 8'h4f));
    n = 1 + $urandom % 8;
    n2 = 1 + $urandom % 8;
    d = 8'($urandom);
    d2 = 8'($urandom);
    hq.push_back(udec_pkg::HS_ACK);
    u_udec_host.out_tx(1'b0, n, d, 1'b0);
    rc({5'h0, 11'(n), 16'h0002}, 32'h07ff0042);
    hq.push_back(udec_pkg::HS_ACK);
    u_udec_host.out_tx(1'b0, n2, d2, 1'b0);
    rc({5'h0, 11'(n), 16'h0042}, 32'h07ff0042);
    hq.push_back(udec_pkg::HS_NAK);
    u_udec_host.out_tx(1'b0, 1, d, 1'b0);
    for (k = 0; k < n; k++)
      rd(udec_pkg::REG_FDR, {24'h0, d + 8'(k)});
    rc(32'h0, 32'h07ff0000);
    wc(csr(3'h2, 1'b1, 8'h4d));
    rc({5'h0, 11'(n2), 16'h0040}, 32'h07ff0042);
    for (k = 0; k < n2; k++)
      rd(udec_pkg::REG_FDR, {24'h0, d2 + 8'(k)});
    wc(csr(3'h2, 1'b1, 8'h0f));
    rc(32'h0, 32'h42);
    wc(csr(3'h2, 1'b1, 8'h6f));
    rc(32'h20, 32'h20);
    hq.push_back(udec_pkg::HS_STALL);
    u_udec_host.tok(1'b1);
    rc(32'h08, 32'h08);
    wc(csr(3'h2, 1'b1, 8'h67));
    rc(32'h20, 32'h28);
    wc(csr(3'h2, 1'b1, 8'h4f));
    hq.push_back(udec_pkg::HS_ACK);
    u_udec_host.out_tx(1'b0, 0, d, 1'b0);
    wc(csr(3'h2, 1'b1, 8'h0d));
    wc(csr(3'h6, 1'b1, 8'h4f));
    rc(32'h0, 32'h10);
    for (k = 0; k < n; k++)
      wr(udec_pkg::REG_FDR, {24'h0, d + 8'(k)});
    wc(csr(3'h6, 1'b1, 8'h5f));
    rc(32'h10, 32'h11);
    wr(udec_pkg::REG_FDR, 32'hee);
    for (k = 0; k < n; k++)
      tq.push_back({23'h0, k == n - 1, d + 8'(k)});
    u_udec_host.in_tx(1'b1);
    rc(32'h01, 32'h11);
    wc(csr(3'h6, 1'b1, 8'h4e));
    hq.push_back(udec_pkg::HS_NAK);
    u_udec_host.tok(1'b0);
    wc(csr(3'h1, 1'b1, 8'h4f));
    u_udec_host.out_tx(1'b0, 3, d, 1'b1);
    rc(32'h08, 32'h08);
    wc(csr(3'h1, 1'b1, 8'h47));
    rc(32'h0, 32'h08);
    wc(csr(3'h1, 1'b1, 8'h0d));
    wc(csr(3'h0, 1'b0, 8'h4f));
    hq.push_back(udec_pkg::HS_ACK);
    u_udec_host.out_tx(1'b1, 8, d, 1'b0);
    rc(32'h04, 32'h04);
    hq.push_back(udec_pkg::HS_NAK);
    u_udec_host.tok(1'b1);
    wc(csr(3'h0, 1'b0, 8'hcf));
    wc(csr(3'h0, 1'b0, 8'hc9));
    hq.push_back(udec_pkg::HS_NAK);
    u_udec_host.tok(1'b1);
    wr(udec_pkg::REG_FDR, {24'h0, d2});
    wc(csr(3'h0, 1'b0, 8'hdf));
    tq.push_back({23'h0, 1'b1, d2});
    u_udec_host.in_tx(1'b1);
    hq.push_back(udec_pkg::HS_ACK);
    u_udec_host.out_tx(1'b0, 0, d, 1'b0);
    repeat (10) @(posedge MCLK);
    RESET_N <= 1'b0;
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    chk("xcvr_off", 32'h1, {31'h0, XCVR_OFF});
    rd(udec_pkg::REG_TXVC, 32'h100);
    rc(32'h8000);
    repeat (10) @(posedge MCLK);
    chk("pending", 32'h0, 32'(rq.size() + hq.size() + tq.size()));
    stop_test();
  end
endmodule : udec_endpoint_tb
bind udec_endpoint udec_props u_udec_props (.MCLK(MCLK), .RESET_N(RESET_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SIE_IN(SIE_IN), .SIE_OUT(SIE_OUT), .XCVR_OFF(XCVR_OFF));
